/* File: shared/i2c_slave_regs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef I2C_SLAVE_REGS_SVH
`define I2C_SLAVE_REGS_SVH
`define OFF_CONTROL_FIRST  4'h0
`define OFF_STATUS_CONTROL 4'h4
`define OFF_DATA_BUFFER    4'h8
`define OFF_OWN_ADDRESS    4'hC
`define OFF_TIMEOUT_CTRL   4'h0
`define PAGE_TIMEOUT_CTRL  1'b1
`define BIT_BUS_ENABLE     0
`define BIT_ADDR_MATCH     6
`define BIT_BUS_BUSY       5
`define BIT_TX_SELECT      4
`define BIT_ACK_OUT        3
`define BIT_READ_REQ       2
`define BIT_ACK_IN         0
`define BIT_TO_ENABLE      7
`define BIT_TO_FLAG        6
`define RST_CONTROL_FIRST  8'h00
`define RST_OWN_ADDRESS    8'h00
`define RST_DATA_BUFFER    8'h00
`define RST_TIMEOUT_CTRL   8'h00
`define SUB_CLK_DIVIDE     5'h1F
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`endif

/* File: shared/i2c_slave_pkg.sv */
// Types used by the bus slave engine, including its time-out control register
package i2c_slave_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_HOLD, ST_DATA, ST_ACK, ST_WAIT_STOP
  } state_type;
  typedef struct packed {
    logic addr_match_flag;
    logic bus_busy_flag;
    logic slave_transmit_select;
    logic ack_out_value;
    logic master_read_request_flag;
    logic ack_in_flag;
  } bus_status_type;
  typedef struct packed {
    logic       timeout_enable;
    logic       timeout_flag;
    logic [5:0] timeout_period_select;
  } timeout_ctrl_type;
endpackage

/* File: rtl/bus_timeout.sv */
// Bus lockup time-out counter clocked by the subsystem clock divided by 32
`timescale 1ns/1ps
`include "i2c_slave_regs.svh"
module bus_timeout (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       sub_clk_i,
  input  wire logic       enable_i,
  input  wire logic [5:0] period_i,
  input  wire logic       arm_i,
  input  wire logic       scl_fall_i,
  input  wire logic       stop_i,
  output logic            expire_o
);
  logic       sub_s1_reg;
  logic       sub_s2_reg;
  logic       sub_s3_reg;
  logic [4:0] pre_reg;
  logic [5:0] count_reg;
  logic       run_reg;
  wire        sub_rise = sub_s2_reg & ~sub_s3_reg;
  wire        tick     = sub_rise && pre_reg == `SUB_CLK_DIVIDE;
  wire        expire   = run_reg & enable_i & tick & count_reg == period_i;

  always_ff @(posedge clk_i) begin
    sub_s1_reg <= sub_clk_i;
    sub_s2_reg <= sub_s1_reg;
    sub_s3_reg <= sub_s2_reg;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_reg <= 1'b0;
    end else if (stop_i || expire || !enable_i) begin
      run_reg <= 1'b0;
    end else if (arm_i) begin
      run_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || scl_fall_i || arm_i || !run_reg) begin
      pre_reg   <= 5'h00;
      count_reg <= 6'h00;
    end else if (sub_rise) begin
      pre_reg <= pre_reg + 5'h01;
      if (tick) begin
        count_reg <= count_reg + 6'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      expire_o <= 1'b0;
    end else begin
      expire_o <= expire;
    end
  end
endmodule

/* File: rtl/i2c_slave_top.sv */
// I2C slave byte engine with AXI4-Lite registers and bus lockup time-out
`timescale 1ns/1ps
`include "i2c_slave_regs.svh"
module i2c_slave_top (
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  input  wire logic [4:0]  AWADDR_I,
  input  wire logic        AWVALID_I,
  output logic             AWREADY_O,
  input  wire logic [31:0] WDATA_I,
  input  wire logic [3:0]  WSTRB_I,
  input  wire logic        WVALID_I,
  output logic             WREADY_O,
  output logic [1:0]       BRESP_O,
  output logic             BVALID_O,
  input  wire logic        BREADY_I,
  input  wire logic [4:0]  ARADDR_I,
  input  wire logic        ARVALID_I,
  output logic             ARREADY_O,
  output logic [31:0]      RDATA_O,
  output logic [1:0]       RRESP_O,
  output logic             RVALID_O,
  input  wire logic        RREADY_I,
  input  wire logic        SCL_I,
  output logic             SCL_O,
  output logic             SCL_OE_O,
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OE_O,
  input  wire logic        SUB_CLK_I,
  output logic             IRQ_O
);
  function automatic logic hit(input logic [4:0] addr, input logic [4:0] off);
    hit = addr[4:2] == off[4:2];
  endfunction

  localparam logic [4:0] A_C0 = {1'b0, `OFF_CONTROL_FIRST};
  localparam logic [4:0] A_C1 = {1'b0, `OFF_STATUS_CONTROL};
  localparam logic [4:0] A_DB = {1'b0, `OFF_DATA_BUFFER};
  localparam logic [4:0] A_OA = {1'b0, `OFF_OWN_ADDRESS};
  localparam logic [4:0] A_TO = {`PAGE_TIMEOUT_CTRL, `OFF_TIMEOUT_CTRL};

  logic                        scl_s1_reg, scl_s2_reg, scl_s3_reg;
  logic                        sda_s1_reg, sda_s2_reg, sda_s3_reg;
  i2c_slave_pkg::state_type    state_reg;
  i2c_slave_pkg::bus_status_type st_reg;
  i2c_slave_pkg::timeout_ctrl_type to_reg;
  logic [3:0]                  cnt_reg;
  logic [7:0]                  shift_reg;
  logic [7:0]                  data_reg;
  logic [7:0]                  own_reg;
  logic [7:0]                  ctl0_reg;
  logic                        aw_full_reg, w_full_reg;
  logic [4:0]                  aw_addr_reg;
  logic [7:0]                  w_data_reg;
  logic                        w_lane_reg;
  logic                        expire;

  // Bus line conditions from the synchronised copies only
  wire scl_rise = scl_s2_reg & ~scl_s3_reg;
  wire scl_fall = ~scl_s2_reg & scl_s3_reg;
  wire start    = scl_s2_reg & scl_s3_reg & sda_s3_reg & ~sda_s2_reg;
  wire stop     = scl_s2_reg & scl_s3_reg & ~sda_s3_reg & sda_s2_reg;
  wire is_tx    = st_reg.slave_transmit_select;
  wire addr_end = state_reg == i2c_slave_pkg::ST_ADDR && scl_fall && cnt_reg == 4'h8;
  wire addr_hit = addr_end && ctl0_reg[`BIT_BUS_ENABLE] && shift_reg[7:1] == own_reg[7:1];
  wire byte_end = state_reg == i2c_slave_pkg::ST_DATA && scl_fall && cnt_reg == 4'h8;
  wire ack_end  = state_reg == i2c_slave_pkg::ST_ACK && scl_fall;

  // Register bus decode
  wire wr_go    = aw_full_reg & w_full_reg & ~BVALID_O;
  wire wr_lane  = wr_go & w_lane_reg;
  wire wr_c0    = wr_lane & hit(aw_addr_reg, A_C0) & ~aw_addr_reg[4];
  wire wr_c1    = wr_lane & hit(aw_addr_reg, A_C1) & ~aw_addr_reg[4];
  wire wr_db    = wr_lane & hit(aw_addr_reg, A_DB) & ~aw_addr_reg[4];
  wire wr_oa    = wr_lane & hit(aw_addr_reg, A_OA) & ~aw_addr_reg[4];
  wire wr_to    = wr_lane & hit(aw_addr_reg, A_TO) & aw_addr_reg[4];
  wire wr_ok    = ~aw_addr_reg[4] | hit(aw_addr_reg, A_TO);
  wire rd_go    = ARVALID_I & ARREADY_O;
  wire rd_ok    = ~ARADDR_I[4] | hit(ARADDR_I, A_TO);
  wire rd_db    = rd_go & ~ARADDR_I[4] & hit(ARADDR_I, A_DB);
  wire in_hold  = state_reg == i2c_slave_pkg::ST_HOLD;
  wire rel_tx   = in_hold & wr_db & is_tx;
  wire rel_rx   = in_hold & rd_db & ~is_tx;
  wire [7:0] c1_view = {1'b0, st_reg.addr_match_flag, st_reg.bus_busy_flag,
                        st_reg.slave_transmit_select, st_reg.ack_out_value,
                        st_reg.master_read_request_flag, 1'b0, st_reg.ack_in_flag};
  wire [7:0] rd_mux = ARADDR_I[4] ? to_reg :
                      hit(ARADDR_I, A_C0) ? ctl0_reg :
                      hit(ARADDR_I, A_C1) ? c1_view :
                      hit(ARADDR_I, A_DB) ? data_reg : {own_reg[7:1], 1'b0};

  assign SCL_O = 1'b0;
  assign SDA_O = 1'b0;

  always_ff @(posedge CLK_I) begin
    scl_s1_reg <= SCL_I;
    scl_s2_reg <= scl_s1_reg;
    scl_s3_reg <= scl_s2_reg;
    sda_s1_reg <= SDA_I;
    sda_s2_reg <= sda_s1_reg;
    sda_s3_reg <= sda_s2_reg;
  end

  bus_timeout u_timeout (
    .clk_i      (CLK_I),
    .rst_i      (RST_I),
    .sub_clk_i  (SUB_CLK_I),
    .enable_i   (to_reg.timeout_enable),
    .period_i   (to_reg.timeout_period_select),
    .arm_i      (addr_hit),
    .scl_fall_i (scl_fall),
    .stop_i     (stop),
    .expire_o   (expire)
  );

  // Write address and data channels, taken in either order
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      AWREADY_O   <= 1'b0;
      WREADY_O    <= 1'b0;
      BVALID_O    <= 1'b0;
      BRESP_O     <= `RESP_OKAY;
      aw_addr_reg <= 5'h00;
      w_data_reg  <= 8'h00;
      w_lane_reg  <= 1'b0;
    end else begin
      AWREADY_O <= ~aw_full_reg & ~(AWVALID_I & AWREADY_O);
      WREADY_O  <= ~w_full_reg & ~(WVALID_I & WREADY_O);
      if (AWVALID_I && AWREADY_O) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= AWADDR_I;
      end
      if (WVALID_I && WREADY_O) begin
        w_full_reg <= 1'b1;
        w_data_reg <= WDATA_I[7:0];
        w_lane_reg <= WSTRB_I[0];
      end
      if (wr_go) begin
        BVALID_O <= 1'b1;
        BRESP_O  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (BVALID_O && BREADY_I) begin
        BVALID_O    <= 1'b0;
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
      end
    end
  end

  // Read channel; a read of the data buffer doubles as the dummy read
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ARREADY_O <= 1'b0;
      RVALID_O  <= 1'b0;
      RDATA_O   <= 32'h0000_0000;
      RRESP_O   <= `RESP_OKAY;
    end else if (rd_go) begin
      ARREADY_O <= 1'b0;
      RVALID_O  <= 1'b1;
      RDATA_O   <= {24'h00_0000, rd_ok ? rd_mux : 8'h00};
      RRESP_O   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (RVALID_O && RREADY_I) begin
      RVALID_O  <= 1'b0;
      ARREADY_O <= 1'b1;
    end else begin
      ARREADY_O <= ~RVALID_O;
    end
  end

  // Registers that a time-out leaves untouched
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ctl0_reg <= `RST_CONTROL_FIRST;
      own_reg  <= `RST_OWN_ADDRESS;
      data_reg <= `RST_DATA_BUFFER;
    end else begin
      if (wr_c0) ctl0_reg <= w_data_reg;
      if (wr_oa) own_reg <= {w_data_reg[7:1], 1'b0};
      if (byte_end && !is_tx) begin
        data_reg <= shift_reg;
      end else if (wr_db) begin
        data_reg <= w_data_reg;
      end
    end
  end

  // Time-out control; hardware set of the flag wins over a software clear
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      to_reg <= `RST_TIMEOUT_CTRL;
    end else begin
      if (wr_to) to_reg.timeout_period_select <= w_data_reg[5:0];
      if (expire) begin
        to_reg.timeout_enable <= 1'b0;
        to_reg.timeout_flag   <= 1'b1;
      end else begin
        if (wr_to) to_reg.timeout_enable <= w_data_reg[`BIT_TO_ENABLE];
        if (wr_to && !w_data_reg[`BIT_TO_FLAG]) to_reg.timeout_flag <= 1'b0;
      end
    end
  end

  // Bus engine and status/control register
  always_ff @(posedge CLK_I) begin
    if (RST_I || expire) begin
      state_reg <= i2c_slave_pkg::ST_IDLE;
      st_reg    <= '0;
      cnt_reg   <= 4'h0;
      shift_reg <= 8'h00;
      SDA_OE_O  <= 1'b0;
      SCL_OE_O  <= 1'b0;
      IRQ_O     <= expire;
    end else begin
      IRQ_O <= 1'b0;
      if (wr_c1) begin
        st_reg.slave_transmit_select <= w_data_reg[`BIT_TX_SELECT];
        st_reg.ack_out_value         <= w_data_reg[`BIT_ACK_OUT];
      end
      if (start) begin
        state_reg <= i2c_slave_pkg::ST_ADDR;
        st_reg.bus_busy_flag <= 1'b1;
        cnt_reg   <= 4'h0;
        SDA_OE_O  <= 1'b0;
        SCL_OE_O  <= 1'b0;
      end else if (stop) begin
        state_reg <= i2c_slave_pkg::ST_IDLE;
        st_reg.bus_busy_flag <= 1'b0;
        SDA_OE_O  <= 1'b0;
        SCL_OE_O  <= 1'b0;
      end else begin
        if (scl_rise) begin
          shift_reg <= {shift_reg[6:0], sda_s2_reg};
          if (cnt_reg != 4'h8) cnt_reg <= cnt_reg + 4'h1;
        end
        case (state_reg)
          i2c_slave_pkg::ST_ADDR: begin
            if (addr_hit) begin
              state_reg <= i2c_slave_pkg::ST_ADDR_ACK;
              st_reg.addr_match_flag          <= 1'b1;
              st_reg.master_read_request_flag <= shift_reg[0];
              SDA_OE_O <= 1'b1;
              IRQ_O    <= 1'b1;
            end else if (addr_end) begin
              state_reg <= i2c_slave_pkg::ST_WAIT_STOP;
            end
          end
          i2c_slave_pkg::ST_ADDR_ACK: begin
            if (scl_fall) begin
              state_reg <= i2c_slave_pkg::ST_HOLD;
              SDA_OE_O  <= 1'b0;
              SCL_OE_O  <= 1'b1;
            end
          end
          i2c_slave_pkg::ST_HOLD: begin
            if (rel_tx || rel_rx) begin
              state_reg <= i2c_slave_pkg::ST_DATA;
              SCL_OE_O  <= 1'b0;
              cnt_reg   <= 4'h0;
              if (rel_tx) begin
                shift_reg <= w_data_reg;
                SDA_OE_O  <= ~w_data_reg[7];
              end
            end
          end
          i2c_slave_pkg::ST_DATA: begin
            if (byte_end) begin
              state_reg <= i2c_slave_pkg::ST_ACK;
              SDA_OE_O  <= is_tx ? 1'b0 : ~st_reg.ack_out_value;
            end else if (scl_fall && is_tx) begin
              SDA_OE_O <= ~shift_reg[7];
            end
          end
          i2c_slave_pkg::ST_ACK: begin
            if (scl_rise && is_tx) st_reg.ack_in_flag <= sda_s2_reg;
            if (ack_end) begin
              st_reg.addr_match_flag <= 1'b0;
              IRQ_O    <= 1'b1;
              SDA_OE_O <= 1'b0;
              if (is_tx && st_reg.ack_in_flag) begin
                state_reg <= i2c_slave_pkg::ST_WAIT_STOP;
              end else begin
                state_reg <= i2c_slave_pkg::ST_HOLD;
                SCL_OE_O  <= 1'b1;
              end
            end
          end
          default: begin
            SDA_OE_O <= 1'b0;
          end
        endcase
      end
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  sequence s_rx_byte_done;
    byte_end && !is_tx && !start && !stop && !expire;
  endsequence

  a_busy_on_start: assert property (start && !expire |=> st_reg.bus_busy_flag)
    else $error("busy flag not set after start");
  a_busy_on_stop: assert property (stop && !start && !expire |=> !st_reg.bus_busy_flag)
    else $error("busy flag not cleared after stop");
  a_addr_ack_drive: assert property (addr_hit && !expire
    |=> SDA_OE_O && IRQ_O && st_reg.addr_match_flag)
    else $error("address match not acknowledged");
  a_rw_capture: assert property (addr_hit && !expire
    |=> st_reg.master_read_request_flag == $past(shift_reg[0]))
    else $error("read request flag not captured");
  a_scl_held: assert property (in_hold && !rel_tx && !rel_rx && !start && !stop && !expire
    && SCL_OE_O |=> SCL_OE_O)
    else $error("SCL released without data access");
  a_tx_first_bit: assert property (rel_tx && !start && !stop && !expire
    |=> !SCL_OE_O && SDA_OE_O == ~data_reg[7])
    else $error("first transmit bit wrong");
  a_rx_ack_value: assert property (s_rx_byte_done
    |=> SDA_OE_O == ~st_reg.ack_out_value && data_reg == $past(shift_reg))
    else $error("receive acknowledge or byte store wrong");
  a_nack_release: assert property (ack_end && is_tx && st_reg.ack_in_flag && !start
    && !stop && !expire |=> !SDA_OE_O && !SCL_OE_O
    && state_reg == i2c_slave_pkg::ST_WAIT_STOP)
    else $error("SDA not released after missing acknowledge");
  a_timeout_effect: assert property (expire |=> to_reg.timeout_flag
    && !to_reg.timeout_enable && IRQ_O && st_reg == '0 && !SCL_OE_O)
    else $error("time-out effects missing");
  a_flag_sticky: assert property (to_reg.timeout_flag && !wr_to
    |=> to_reg.timeout_flag)
    else $error("time-out flag lost without a write");
endmodule

/* File: testbench/i2c_master_model.sv */
// Behavioural I2C bus master with open-drain outputs, 1 means released
`timescale 1ns/1ps
module i2c_master_model #(
  parameter int QTR   = 8,
  parameter int LIMIT = 4000
) (
  input  wire logic clk_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  int hangs = 0;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic pause(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Release SCL and wait while the slave stretches it low
  task automatic rise_scl();
    int n;
    n = 0;
    scl_o <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (scl_i !== 1'b1 && n < LIMIT);
    if (n >= LIMIT) hangs++;
  endtask
  task automatic start();
    sda_o <= 1'b1;
    pause(QTR);
    rise_scl();
    pause(2 * QTR);
    sda_o <= 1'b0;
    pause(2 * QTR);
    scl_o <= 1'b0;
    pause(QTR);
  endtask
  task automatic put_bit(input logic b, output logic seen);
    sda_o <= b;
    pause(QTR);
    rise_scl();
    pause(QTR);
    seen = sda_i;
    pause(QTR);
    scl_o <= 1'b0;
    pause(QTR);
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ack, output logic [7:0] rx,
                      output logic ack_seen);
    for (int i = 7; i >= 0; i--) put_bit(tx[i], rx[i]);
    put_bit(ack, ack_seen);
  endtask
  task automatic stop();
    sda_o <= 1'b0;
    pause(QTR);
    rise_scl();
    pause(2 * QTR);
    sda_o <= 1'b1;
    pause(2 * QTR);
  endtask
endmodule

/* File: testbench/tb_i2c_slave_top.sv */
// Bench: register table, reset, receive, transmit, foreign address and time-out
`timescale 1ns/1ps
`include "i2c_slave_regs.svh"
module tb_i2c_slave_top;
  localparam int LIMIT = 5000;
  localparam logic [4:0] A_TO = 5'h10;
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic [7:0] rexp;
    logic [1:0] resp;
  } row_type;
  row_type rows [6] = '{
    '{5'h0C, 8'hA5, 8'hA4, `RESP_OKAY},
    '{5'h10, 8'hFF, 8'hBF, `RESP_OKAY},
    '{5'h04, 8'hFF, 8'h18, `RESP_OKAY},
    '{5'h08, 8'h69, 8'h69, `RESP_OKAY},
    '{5'h00, 8'h01, 8'h01, `RESP_OKAY},
    '{5'h14, 8'h77, 8'h00, `RESP_SLVERR}};
  logic        clk = 1'b0, rst = 1'b1, sub_clk = 1'b0;
  logic [2:0]  sub_div = 3'h0;
  logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h00000000;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        scl_m, sda_m, scl_out, sda_out, scl_oe, sda_oe;
  wire         scl_w = scl_m & (scl_oe ? scl_out : 1'b1);
  wire         sda_w = sda_m & (sda_oe ? sda_out : 1'b1);
  int          err_total = 0, num_checks = 0, irq_cnt = 0, irq_seen = 0;
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    sub_div <= sub_div + 3'h1;
    if (sub_div == 3'h7) sub_clk <= ~sub_clk;
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
  end
  i2c_slave_top u_i2c_slave_top (.CLK_I(clk), .RST_I(rst), .AWADDR_I(awaddr),
    .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(4'hF),
    .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid),
    .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
    .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
    .SCL_I(scl_w), .SCL_O(scl_out), .SCL_OE_O(scl_oe), .SDA_I(sda_w), .SDA_O(sda_out),
    .SDA_OE_O(sda_oe), .SUB_CLK_I(sub_clk), .IRQ_O(irq));
  i2c_master_model u_i2c_master_model (.clk_i(clk), .scl_i(scl_w), .sda_i(sda_w),
    .scl_o(scl_m), .sda_o(sda_m));
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_bit(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic tick(inout int n);
    @(posedge clk);
    n++;
    if (n > LIMIT) begin
      err_total++;
      report_and_stop();
    end
  endtask
  task automatic axi_write(input logic [4:0] a, input logic [7:0] d, output logic [1:0] resp);
    int n;
    logic aw_done, w_done;
    n = 0;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      tick(n);
      if (awvalid && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do tick(n); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [4:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do tick(n); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do tick(n); while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    check_word("write response", `RESP_OKAY, r);
  endtask
  task automatic rd_check(input string what, input logic [4:0] a, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check_word(what, exp, d);
    check_word("read response", `RESP_OKAY, r);
  endtask
  task automatic wait_irq(output int waited);
    waited = 0;
    while (irq_cnt == irq_seen) tick(waited);
    irq_seen++;
  endtask
  initial begin
    int n;
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] rx;
    logic a0, a1, a2;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      axi_write(rows[i].addr, rows[i].wdata, r);
      check_word("write response", rows[i].resp, r);
      axi_read(rows[i].addr, d, r);
      check_word("read response", rows[i].resp, r);
      check_word("read data", rows[i].rexp, d);
    end
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 5; a++) rd_check("reset value", 5'(a * 4), 8'h00);
    wr(`OFF_OWN_ADDRESS, 8'h55);
    wr(`OFF_CONTROL_FIRST, 8'h01);
    wr(A_TO, 8'h82);
    fork
      begin
        u_i2c_master_model.start();
        u_i2c_master_model.xfer({7'h2A, 1'b0}, 1'b1, rx, a0);
        u_i2c_master_model.xfer(8'h96, 1'b1, rx, a1);
        u_i2c_master_model.xfer(8'h3C, 1'b1, rx, a2);
        u_i2c_master_model.stop();
      end
      begin
        wait_irq(n);
        rd_check("status after match", `OFF_STATUS_CONTROL, 8'h60);
        repeat (100) @(posedge clk);
        check_bit("scl held", 1'b1, scl_oe);
        axi_read(`OFF_DATA_BUFFER, d, r);
        wait_irq(n);
        wr(`OFF_STATUS_CONTROL, 8'h08);
        rd_check("first byte", `OFF_DATA_BUFFER, 8'h96);
        wait_irq(n);
        rd_check("second byte", `OFF_DATA_BUFFER, 8'h3C);
      end
    join
    check_bit("address ack", 1'b0, a0);
    check_bit("byte ack", 1'b0, a1);
    check_bit("byte nack", 1'b1, a2);
    rd_check("busy after stop", `OFF_STATUS_CONTROL, 8'h08);
    fork
      begin
        u_i2c_master_model.start();
        u_i2c_master_model.xfer({7'h2A, 1'b1}, 1'b1, rx, a0);
        u_i2c_master_model.xfer(8'hFF, 1'b0, rx, a1);
        check_word("first sent", 8'hC3, rx);
        u_i2c_master_model.xfer(8'hFF, 1'b1, rx, a1);
        check_word("second sent", 8'h5A, rx);
        u_i2c_master_model.stop();
      end
      begin
        wait_irq(n);
        rd_check("read request", `OFF_STATUS_CONTROL, 8'h6C);
        wr(`OFF_STATUS_CONTROL, 8'h10);
        // Let the 9th clock of the address pass so the stretch has begun
        repeat (100) @(posedge clk);
        check_bit("scl held tx", 1'b1, scl_oe);
        wr(`OFF_DATA_BUFFER, 8'hC3);
        wait_irq(n);
        rd_check("ack in low", `OFF_STATUS_CONTROL, 8'h34);
        wr(`OFF_DATA_BUFFER, 8'h5A);
        wait_irq(n);
        rd_check("ack in high", `OFF_STATUS_CONTROL, 8'h35);
        check_bit("sda released", 1'b0, sda_oe);
      end
    join
    wr(`OFF_STATUS_CONTROL, 8'h00);
    n = irq_cnt;
    u_i2c_master_model.start();
    u_i2c_master_model.xfer({7'h15, 1'b0}, 1'b1, rx, a0);
    check_bit("foreign address ack", 1'b1, a0);
    u_i2c_master_model.stop();
    check_word("foreign irq count", n, irq_cnt);
    repeat (2000) @(posedge clk);
    rd_check("no expiry after stop", A_TO, 8'h82);
    fork
      begin
        u_i2c_master_model.start();
        u_i2c_master_model.xfer({7'h2A, 1'b0}, 1'b1, rx, a0);
        u_i2c_master_model.stop();
      end
      begin
        wait_irq(n);
        wait_irq(n);
        check_bit("expiry window", 1'b1, n >= 1040 && n <= 1600);
        rd_check("flag set enable clear", A_TO, 8'h42);
        rd_check("status cleared", `OFF_STATUS_CONTROL, 8'h00);
        rd_check("own address kept", `OFF_OWN_ADDRESS, 8'h54);
        rd_check("buffer kept", `OFF_DATA_BUFFER, 8'h5A);
        check_bit("scl released", 1'b0, scl_oe);
      end
    join
    wr(A_TO, 8'h02);
    rd_check("flag cleared", A_TO, 8'h02);
    check_word("master stalls", 32'h00000000, u_i2c_master_model.hangs);
    report_and_stop();
  end
endmodule
